// file: design/rst_ctl_pkg.sv
/*
 * package for the reset controller: register map, reset values, timing counts,
 * reset kinds and carrier structs.
 * assumes a single 50 MHz system clock and an AXI4-Lite register bus.
 */
`default_nettype none
package rst_ctl_pkg;
    // axi4-lite byte offsets
    localparam logic [7:0] OFF_STATUS  = 8'h00;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h04;
    localparam logic [7:0] OFF_IRQ_EN  = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFF_CTRL    = 8'h10;
    localparam logic [7:0] OFF_WDSEL   = 8'h14;
    localparam logic [7:0] OFF_TMRCTL  = 8'h18;
    localparam logic [7:0] OFF_PORTS   = 8'h1C;
    localparam logic [7:0] OFF_BANK    = 8'h20;
    localparam logic [7:0] OFF_NVCTL   = 8'h24;

    // status word bit positions
    localparam int STAT_TO_BIT  = 5;
    localparam int STAT_PD_BIT  = 4;
    localparam int STAT_RUN_BIT = 0;
    // control register bit positions (software pulses)
    localparam int CTRL_HALT_BIT  = 0;
    localparam int CTRL_CLRWD_BIT = 1;

    // reset values
    localparam logic [7:0] RST_WDSEL  = 8'h07;
    localparam logic [7:0] RST_TMRCTL = 8'h08;
    localparam logic [7:0] RST_PORT8  = 8'hFF;
    localparam logic [2:0] RST_PORT3  = 3'h7;
    localparam logic [7:0] RST_BANK   = 8'h00;
    localparam logic [5:0] RST_INTERRUPT_CONTROL   = 6'h00;
    localparam logic [3:0] RST_NVCTL  = 4'h8;
    localparam logic [9:0] RST_PC     = 10'h000;
    localparam logic [1:0] RST_SP     = 2'h0;

    // timing counts
    localparam int STARTUP_CYCLES = 1024;
    localparam int OPTLOAD_CYCLES = 16;

    // interrupt event bits
    localparam int EV_POWERUP = 0;
    localparam int EV_PIN_RUN = 1;
    localparam int EV_PIN_HLT = 2;
    localparam int EV_WD_RUN  = 3;
    localparam int EV_WD_HLT  = 4;
    localparam int EV_WAKE    = 5;
    localparam int EV_W       = 6;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_POWERUP,
        KIND_PIN_RUN,
        KIND_PIN_HALT,
        KIND_WD_RUN,
        KIND_WD_HALT,
        KIND_WAKE
    } reset_kind_t;

    typedef struct packed {
        logic [7:0] watchdog_select;
        logic [7:0] timer_control;
        logic [7:0] port_a_data;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_data;
        logic [7:0] port_b_direction;
        logic [2:0] port_c_data;
        logic [2:0] port_c_direction;
        logic [7:0] bank_pointer;
        logic [5:0] interrupt_control;
        logic [3:0] nonvolatile_control;
    } reg_defaults_t;

    typedef struct packed {
        logic       chip_reset;
        logic       warm_reset;
        logic       clear_prescaler;
        logic       clear_watchdog;
        logic       load_defaults;
        logic       timer_off;
        logic       ints_disable;
        logic [9:0] program_counter;
        logic [1:0] stack_pointer;
    } unit_reset_t;
endpackage
`default_nettype wire

// file: design/mcu_reset_controller.sv
/*
 * reset controller: merges pin, watchdog and power-up resets, keeps the
 * time-out and power-down flags, times start-up and option-load delays and
 * drives reset values to the functional units. axi4-lite slave for status.
 * assumes watchdog_timeout, halt_exec, watchdog_clear_instruction and wake_event are one-cycle
 * pulses on aclk from core logic; ext_reset_n_pin is asynchronous.
 */
`default_nettype none
module mcu_reset_controller #(
    parameter int STARTUP_CYCLES = rst_ctl_pkg::STARTUP_CYCLES,
    parameter int OPTLOAD_CYCLES = rst_ctl_pkg::OPTLOAD_CYCLES
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     ext_reset_n_pin,
    input  wire logic                     watchdog_timeout,
    input  wire logic                     halt_exec,
    input  wire logic                     watchdog_clear_instruction,
    input  wire logic                     wake_event,
    output logic                          cpu_hold,
    output logic                          halted,
    output logic                          timeout_flag,
    output logic                          powerdown_flag,
    output rst_ctl_pkg::unit_reset_t      unit_reset,
    output rst_ctl_pkg::reg_defaults_t    reg_defaults,
    output logic                          irq,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);
    localparam int CW = $clog2(STARTUP_CYCLES + OPTLOAD_CYCLES + 1);

    logic [2:0]                  pin_sync;
    logic                        pin_low;
    logic                        pin_low_q;
    logic                        powerup_pend;
    rst_ctl_pkg::reset_kind_t    kind;
    logic [CW-1:0]               delay_cnt;
    logic                        sw_halt;
    logic                        sw_clrwd;
    logic [rst_ctl_pkg::EV_W-1:0] irq_status;
    logic [rst_ctl_pkg::EV_W-1:0] irq_enable;
    logic [rst_ctl_pkg::EV_W-1:0] irq_clear;
    logic [rst_ctl_pkg::EV_W-1:0] events;
    logic                        do_halt;
    logic                        do_clrwd;

    // three-stage pin synchroniser; a change counts once stages two and three agree
    // pin synchronise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync <= 3'h7;
        end else begin
            pin_sync <= {pin_sync[1:0], ext_reset_n_pin};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_low <= 1'b0;
        end else if (pin_sync[1] == pin_sync[2]) begin
            pin_low <= ~pin_sync[2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_low_q <= 1'b0;
        end else begin
            pin_low_q <= pin_low;
        end
    end

    // reset source classification; power-up is the release of aresetn
    // four reset sources
    always_comb begin
        kind = rst_ctl_pkg::KIND_NONE;
        if (powerup_pend) begin
            kind = rst_ctl_pkg::KIND_POWERUP;
        end else if (pin_low && !pin_low_q) begin
            kind = halted ? rst_ctl_pkg::KIND_PIN_HALT : rst_ctl_pkg::KIND_PIN_RUN;
        end else if (watchdog_timeout) begin
            kind = halted ? rst_ctl_pkg::KIND_WD_HALT : rst_ctl_pkg::KIND_WD_RUN;
        end else if (halted && wake_event) begin
            kind = rst_ctl_pkg::KIND_WAKE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            powerup_pend <= 1'b1;
        end else begin
            powerup_pend <= 1'b0;
        end
    end

    assign do_halt  = halt_exec | sw_halt;
    assign do_clrwd = watchdog_clear_instruction | sw_clrwd;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halted <= 1'b0;
        end else if (kind != rst_ctl_pkg::KIND_NONE) begin
            halted <= 1'b0;
        end else if (do_halt && !cpu_hold) begin
            halted <= 1'b1;
        end
    end

    // start-up delay, plus option-load on power-up and running pin/watchdog resets; hold extends while pin is low
    // startup delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delay_cnt <= '0;
        end else begin
            case (kind)
                rst_ctl_pkg::KIND_POWERUP,
                rst_ctl_pkg::KIND_PIN_RUN,
                rst_ctl_pkg::KIND_WD_RUN: begin
                    delay_cnt <= CW'(STARTUP_CYCLES + OPTLOAD_CYCLES);
                end
                rst_ctl_pkg::KIND_PIN_HALT,
                rst_ctl_pkg::KIND_WD_HALT,
                rst_ctl_pkg::KIND_WAKE: begin
                    delay_cnt <= CW'(STARTUP_CYCLES);
                end
                default: begin
                    if (pin_low) begin
                        delay_cnt <= delay_cnt;
                    end else if (delay_cnt != '0) begin
                        delay_cnt <= delay_cnt - CW'(1);
                    end
                end
            endcase
        end
    end

    assign cpu_hold = (delay_cnt != '0) || pin_low || !aresetn || powerup_pend;

    // flags: the latest cause in a cycle wins over software clear/halt
    // power-up clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_flag   <= 1'b0;
            powerdown_flag <= 1'b0;
        end else begin
            case (kind)
                rst_ctl_pkg::KIND_POWERUP: begin
                    timeout_flag   <= 1'b0;
                    powerdown_flag <= 1'b0;
                end
                rst_ctl_pkg::KIND_PIN_RUN: begin
                    timeout_flag   <= timeout_flag;
                    powerdown_flag <= powerdown_flag;
                end
                rst_ctl_pkg::KIND_PIN_HALT: begin
                    timeout_flag   <= 1'b0;
                    powerdown_flag <= 1'b1;
                end
                rst_ctl_pkg::KIND_WD_RUN: begin
                    timeout_flag   <= 1'b1;
                end
                rst_ctl_pkg::KIND_WD_HALT: begin
                    timeout_flag   <= 1'b1;
                    powerdown_flag <= 1'b1;
                end
                default: begin
                    if (do_halt && !cpu_hold) begin
                        timeout_flag   <= 1'b0;
                        powerdown_flag <= 1'b1;
                    end else if (do_clrwd && !cpu_hold) begin
                        timeout_flag   <= 1'b0;
                        powerdown_flag <= 1'b0;
                    end
                end
            endcase
        end
    end

    // unit reset strobes; warm reset touches only pc and stack pointer
    // warm reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_reset <= '0;
        end else begin
            unit_reset <= '0;
            unit_reset.program_counter <= rst_ctl_pkg::RST_PC;
            unit_reset.stack_pointer   <= rst_ctl_pkg::RST_SP;
            case (kind)
                rst_ctl_pkg::KIND_POWERUP,
                rst_ctl_pkg::KIND_PIN_RUN,
                rst_ctl_pkg::KIND_PIN_HALT,
                rst_ctl_pkg::KIND_WD_RUN: begin
                    unit_reset.chip_reset      <= 1'b1;
                    unit_reset.clear_prescaler <= 1'b1;
                    unit_reset.clear_watchdog  <= 1'b1;
                    unit_reset.load_defaults   <= 1'b1;
                    unit_reset.timer_off       <= 1'b1;
                    unit_reset.ints_disable    <= 1'b1;
                end
                rst_ctl_pkg::KIND_WD_HALT: begin
                    unit_reset.warm_reset <= 1'b1;
                end
                default: begin
                    unit_reset.clear_watchdog <= do_halt | do_clrwd;
                end
            endcase
        end
    end

    always_comb begin
        reg_defaults.watchdog_select     = rst_ctl_pkg::RST_WDSEL;
        reg_defaults.timer_control       = rst_ctl_pkg::RST_TMRCTL;
        reg_defaults.port_a_data         = rst_ctl_pkg::RST_PORT8;
        reg_defaults.port_a_direction    = rst_ctl_pkg::RST_PORT8;
        reg_defaults.port_b_data         = rst_ctl_pkg::RST_PORT8;
        reg_defaults.port_b_direction    = rst_ctl_pkg::RST_PORT8;
        reg_defaults.port_c_data         = rst_ctl_pkg::RST_PORT3;
        reg_defaults.port_c_direction    = rst_ctl_pkg::RST_PORT3;
        reg_defaults.bank_pointer        = rst_ctl_pkg::RST_BANK;
        reg_defaults.interrupt_control   = rst_ctl_pkg::RST_INTERRUPT_CONTROL;
        reg_defaults.nonvolatile_control = rst_ctl_pkg::RST_NVCTL;
    end

    // interrupt events: one sticky bit per reset kind; set wins over clear
    always_comb begin
        events = '0;
        events[rst_ctl_pkg::EV_POWERUP] = (kind == rst_ctl_pkg::KIND_POWERUP);
        events[rst_ctl_pkg::EV_PIN_RUN] = (kind == rst_ctl_pkg::KIND_PIN_RUN);
        events[rst_ctl_pkg::EV_PIN_HLT] = (kind == rst_ctl_pkg::KIND_PIN_HALT);
        events[rst_ctl_pkg::EV_WD_RUN]  = (kind == rst_ctl_pkg::KIND_WD_RUN);
        events[rst_ctl_pkg::EV_WD_HLT]  = (kind == rst_ctl_pkg::KIND_WD_HALT);
        events[rst_ctl_pkg::EV_WAKE]    = (kind == rst_ctl_pkg::KIND_WAKE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | events;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // axi4-lite: write accepted when address and data are both present
    logic wr_go;
    logic rd_go;
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign wr_go         = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go         = s_axi_arvalid && s_axi_arready;

    function automatic logic mapped(input logic [7:0] a);
        return (a == rst_ctl_pkg::OFF_STATUS)  || (a == rst_ctl_pkg::OFF_IRQ_ST) ||
               (a == rst_ctl_pkg::OFF_IRQ_EN)  || (a == rst_ctl_pkg::OFF_IRQ_CLR) ||
               (a == rst_ctl_pkg::OFF_CTRL);
    endfunction

    always_comb begin
        irq_clear = '0;
        sw_halt   = 1'b0;
        sw_clrwd  = 1'b0;
        if (wr_go && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == rst_ctl_pkg::OFF_IRQ_CLR) begin
                irq_clear = s_axi_wdata[rst_ctl_pkg::EV_W-1:0];
            end
            if (s_axi_awaddr == rst_ctl_pkg::OFF_CTRL) begin
                sw_halt  = s_axi_wdata[rst_ctl_pkg::CTRL_HALT_BIT];
                sw_clrwd = s_axi_wdata[rst_ctl_pkg::CTRL_CLRWD_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable <= '0;
        end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == rst_ctl_pkg::OFF_IRQ_EN) begin
            irq_enable <= s_axi_wdata[rst_ctl_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(s_axi_awaddr) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr)
                rst_ctl_pkg::OFF_STATUS: begin
                    s_axi_rdata[rst_ctl_pkg::STAT_TO_BIT]  <= timeout_flag;
                    s_axi_rdata[rst_ctl_pkg::STAT_PD_BIT]  <= powerdown_flag;
                    s_axi_rdata[rst_ctl_pkg::STAT_RUN_BIT] <= ~cpu_hold;
                    s_axi_rdata[1]                         <= halted;
                end
                rst_ctl_pkg::OFF_IRQ_ST: s_axi_rdata[rst_ctl_pkg::EV_W-1:0] <= irq_status;
                rst_ctl_pkg::OFF_IRQ_EN: s_axi_rdata[rst_ctl_pkg::EV_W-1:0] <= irq_enable;
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_startup_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_WAKE) |=>
        (delay_cnt == CW'(STARTUP_CYCLES)) ##0 cpu_hold [*8])
        else $error("hold dropped early after wake");
    a_optload_count: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_WD_RUN) |=> delay_cnt == CW'(STARTUP_CYCLES + OPTLOAD_CYCLES))
        else $error("option load delay missing");
    a_pin_run_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_PIN_RUN) |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("pin reset changed flags");
    a_wd_halt_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_WD_HALT) |=> timeout_flag && powerdown_flag)
        else $error("watchdog wake flags wrong");
    a_pin_halt_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_PIN_HALT) |=> !timeout_flag && powerdown_flag)
        else $error("pin wake flags wrong");
    a_warm_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_WD_HALT) |=> unit_reset.warm_reset && !unit_reset.load_defaults)
        else $error("warm reset loaded defaults");
    a_chip_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_WD_RUN) |=> unit_reset.load_defaults && unit_reset.clear_watchdog)
        else $error("chip reset missed defaults");
    a_wd_run_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_WD_RUN) |=> timeout_flag && $stable(powerdown_flag))
        else $error("time-out flag not set");
    a_powerup_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (kind == rst_ctl_pkg::KIND_POWERUP) |=> !timeout_flag && !powerdown_flag && cpu_hold)
        else $error("power-up flags not cleared");
endmodule
`default_nettype wire

// file: sim/reset_source_model.sv
/*
 * far side model: external reset pin circuit and watchdog overflow source.
 * assumes requests from the bench arrive as one-cycle pulses on aclk.
 */
`default_nettype none
module reset_source_model (
    input  wire logic       aclk,
    input  wire logic       pin_go,
    input  wire logic [7:0] pin_len,
    input  wire logic       wd_go,
    output logic            ext_reset_n_pin,
    output logic            watchdog_timeout
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left = 8'h00;
    logic       wd_q = 1'b0;
    // pin held low for pin_len cycles, so a slow external circuit is modelled
    always @(posedge aclk) begin
        if (pin_go)
            left <= pin_len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end
    always @(posedge aclk) wd_q <= wd_go;
    assign ext_reset_n_pin  = (left == 8'h00);
    assign watchdog_timeout = wd_q;
endmodule
`default_nettype wire

// file: sim/tb_top.sv
/*
 * self-checking bench for the reset controller: reset sources, flags, delays, irq.
 * assumes the design package is compiled first and the far side model is present.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SU = 8;
    localparam int OL = 2;
    logic aclk, aresetn, halt_exec, watchdog_clear_instruction, wake_event, pin_go, wd_go;
    logic ext_reset_n_pin, watchdog_timeout, cpu_hold, halted, timeout_flag, powerdown_flag;
    logic irq, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_len;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, en, lfsr = 32'h82CE6C7D;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, f;
    logic [3:0]  s_axi_wstrb = 4'hF;
    rst_ctl_pkg::unit_reset_t   unit_reset;
    rst_ctl_pkg::reg_defaults_t reg_defaults;
    int n_mismatch = 0, samples_checked = 0, n_chip = 0, n_warm = 0, cyc = 0, c0, w0;

    mcu_reset_controller #(.STARTUP_CYCLES(SU), .OPTLOAD_CYCLES(OL)) dut (
        .aclk, .aresetn, .ext_reset_n_pin, .watchdog_timeout, .halt_exec,
        .watchdog_clear_instruction, .wake_event, .cpu_hold, .halted, .timeout_flag,
        .powerdown_flag, .unit_reset, .reg_defaults, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    reset_source_model src (.aclk, .pin_go, .pin_len, .wd_go, .ext_reset_n_pin,
        .watchdog_timeout);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        // a chip reset only counts when every unit strobe comes with it
        if (unit_reset.chip_reset === 1'b1 &&
            {unit_reset.clear_prescaler, unit_reset.clear_watchdog, unit_reset.load_defaults,
             unit_reset.timer_off, unit_reset.ints_disable} === 5'h1F)
            n_chip <= n_chip + 1;
        if (unit_reset.warm_reset === 1'b1 && unit_reset.load_defaults === 1'b0)
            n_warm <= n_warm + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    // flag pair by cause, {timeout, powerdown}
    function automatic logic [1:0] exp_flags(input int kind, input logic [1:0] old);
        case (kind)
            0: return 2'b00;
            1: return old;
            2: return 2'b01;
            3: return {1'b1, old[0]};
            default: return 2'b11;
        endcase
    endfunction

    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // k: 0 halt, 1 watchdog clear, 2 wake, 3 watchdog overflow
    task automatic kick(input int k);
        @(posedge aclk);
        case (k)
            0: halt_exec <= 1'b1;
            1: watchdog_clear_instruction <= 1'b1;
            2: wake_event <= 1'b1;
            default: wd_go <= 1'b1;
        endcase
        @(posedge aclk);
        {halt_exec, watchdog_clear_instruction, wake_event, wd_go} <= 4'h0;
    endtask

    task automatic pin(input logic [7:0] len);
        @(posedge aclk);
        pin_go <= 1'b1;
        pin_len <= len;
        @(posedge aclk);
        pin_go <= 1'b0;
    endtask

    task automatic hold_len(input int lo, input int hi);
        int n;
        n = 0;
        // sample mid-cycle so n is the number of cycles the hold stood high
        @(negedge aclk);
        repeat (12) if (cpu_hold !== 1'b1) @(negedge aclk);
        while (cpu_hold === 1'b1 && n < 200) begin
            @(negedge aclk);
            n++;
        end
        chk(n >= lo && n <= hi, 1);
    endtask

    initial begin
        {aresetn, halt_exec, watchdog_clear_instruction, wake_event, pin_go, wd_go} = 6'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, pin_len, s_axi_wdata} = 56'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        hold_len(SU + OL - 1, SU + OL + 1);
        chk({timeout_flag, powerdown_flag}, exp_flags(0, 2'b11));
        chk(reg_defaults, {rst_ctl_pkg::RST_WDSEL, rst_ctl_pkg::RST_TMRCTL,
            {4{rst_ctl_pkg::RST_PORT8}}, {2{rst_ctl_pkg::RST_PORT3}}, rst_ctl_pkg::RST_BANK,
            rst_ctl_pkg::RST_INTERRUPT_CONTROL, rst_ctl_pkg::RST_NVCTL});
        chk({unit_reset.program_counter, unit_reset.stack_pointer}, 0);
        $display("test power-up done");
        en = rnd() & 32'h3F;
        axw(rst_ctl_pkg::OFF_IRQ_EN, en);
        chk(r, 2'h0);
        axr(rst_ctl_pkg::OFF_IRQ_EN);
        chk(d, en);
        axr(8'h40);
        chk({r, d}, {2'h2, 32'h0});
        axw(rst_ctl_pkg::OFF_IRQ_EN, 32'h8);
        f = {timeout_flag, powerdown_flag};
        c0 = n_chip;
        kick(3);
        hold_len(SU + OL - 1, SU + OL + 1);
        chk({timeout_flag, powerdown_flag}, exp_flags(3, f));
        chk(n_chip - c0, 1);
        chk(irq, 1);
        axw(rst_ctl_pkg::OFF_IRQ_EN, 32'h0);
        chk(irq, 0);
        axw(rst_ctl_pkg::OFF_IRQ_EN, 32'h8);
        axw(rst_ctl_pkg::OFF_IRQ_CLR, 32'h8);
        axr(rst_ctl_pkg::OFF_IRQ_ST);
        chk({irq, d[3]}, 2'b00);
        $display("test watchdog running done");
        f = {timeout_flag, powerdown_flag};
        c0 = n_chip;
        pin_len = 8'h02 + 8'(rnd() & 32'h0000_0007);
        pin(pin_len);
        hold_len(SU + OL - 1, SU + OL + pin_len + 7);
        chk({timeout_flag, powerdown_flag}, exp_flags(1, f));
        chk(n_chip - c0, 1);
        $display("test pin running done");
        axw(rst_ctl_pkg::OFF_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        chk({halted, timeout_flag, powerdown_flag}, 3'b101);
        c0 = n_chip;
        pin(8'h03);
        hold_len(SU + OL - 1, SU + OL + 10);
        chk({timeout_flag, powerdown_flag}, exp_flags(2, f));
        chk(n_chip - c0, 1);
        $display("test pin halted done");
        kick(0);
        repeat (2) @(posedge aclk);
        c0 = n_chip;
        w0 = n_warm;
        kick(3);
        hold_len(SU - 1, SU + 1);
        chk({timeout_flag, powerdown_flag}, exp_flags(4, f));
        chk({n_warm - w0, n_chip - c0}, {32'd1, 32'd0});
        kick(1);
        repeat (2) @(posedge aclk);
        chk({timeout_flag, powerdown_flag}, 2'b00);
        $display("test watchdog halted done");
        kick(0);
        repeat (2) @(posedge aclk);
        kick(2);
        hold_len(SU - 1, SU + 1);
        axr(rst_ctl_pkg::OFF_STATUS);
        chk({halted, d[5:4], d[1]}, 4'b0010);
        $display("test wake done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        hold_len(SU + OL - 1, SU + OL + 1);
        chk({timeout_flag, powerdown_flag}, exp_flags(0, f));
        $display("test second power-up done");
        stop_test();
    end
endmodule
`default_nettype wire
